// ### hdl/tfie_top.sv
// Timer flag and interrupt-enable block with counter, compare and capture registers
//
// Contract
// - Enable register loads 01 on reset, low power
// - Enable bits 7..4 gate capture A..D requests
// - Enable bits 3,2 gate compare A,B requests
// - Enable bit 1 gates overflow request
// - Enable bit 0 reads 1, writes ignored
// - Status register clears on reset, low power
// - Flags set by hardware only; 0 clears
// - Clear needs prior read of flag as 1
// - Capture A sets flag; buffered moves A to C
// - Capture B sets flag; buffered moves B to D
// - Capture C event sets flag, even when buffered
// - Capture D event sets flag, even when buffered
// - Compare A/B match sets its flag
// - Overflow flag set on wrap to zero
// - Status bit 0 selects clear on match A
// - Counter is 16-bit up-counter, CPU accessible
// - Capture C/D buffer A/B per enable bit
`timescale 1ns/1ps
`include "tfie_map.svh"
module tfie_top #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic lp_entry_i,
  input wire logic count_tick_i,
  input wire logic capture_a_i,
  input wire logic capture_b_i,
  input wire logic capture_c_i,
  input wire logic capture_d_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [7:0] bus_rdata_o,
  output logic capture_a_irq_o,
  output logic capture_b_irq_o,
  output logic capture_c_irq_o,
  output logic capture_d_irq_o,
  output logic compare_a_irq_o,
  output logic compare_b_irq_o,
  output logic counter_overflow_irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Carrier of the status flag register
  tfie_flag_if fl ();

  // Software registers; enable bit 0 is not stored
  logic [7:1] timer_irq_enable;
  logic [7:0] timer_control;
  logic [WIDTH-1:0] compare_reg_a;
  logic [WIDTH-1:0] compare_reg_b;

  // Capture registers, loaded by events only
  logic [WIDTH-1:0] capture_reg_a;
  logic [WIDTH-1:0] capture_reg_b;
  logic [WIDTH-1:0] capture_reg_c;
  logic [WIDTH-1:0] capture_reg_d;

  // Counter and its event pulses
  logic [WIDTH-1:0] free_running_counter;
  logic match_a;
  logic match_b;
  logic overflow;

  // Decode and read path
  logic buffer_a_enable;
  logic buffer_b_enable;
  logic wr_ier;
  logic wr_tcr;
  logic [7:0] next_rdata;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Single-cycle strobes; any unmapped address is ignored on write
  assign wr_ier = bus_wr_i && tfie_pkg::tfie_hit(bus_addr_i, `TFIE_OFF_IER);
  assign wr_tcr = bus_wr_i && tfie_pkg::tfie_hit(bus_addr_i, `TFIE_OFF_TCR);
  // Buffer enables are plain control bits; a change
  // takes effect at the next capture event and never
  // moves a stored value by itself
  assign buffer_a_enable = timer_control[`TFIE_BIT_BUF_A];
  assign buffer_b_enable = timer_control[`TFIE_BIT_BUF_B];

  // ----------------------------------------------------------------
  // Interrupt enable register
  // ----------------------------------------------------------------
  // Bit 0 is not stored at all; it is a constant 1 on read
  // Low-power entry rewrites the reset value
  // A write to bit 0 is lost here, not masked on read
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_irq_enable <= 7'(`TFIE_RST_IER >> 1);
    end else if (lp_entry_i) begin
      timer_irq_enable <= 7'(`TFIE_RST_IER >> 1);
    end else if (wr_ier) begin
      timer_irq_enable <= bus_wdata_i[7:1];
    end
  end

  // ----------------------------------------------------------------
  // Timer control register (buffer enables live here)
  // ----------------------------------------------------------------
  // Edge and clock-select bits are kept for read-back
  // only; the logic using them sits outside this block
  // Bits 3 and 2 select buffering of capture A and B
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_control <= `TFIE_RST_TCR;
    end else if (lp_entry_i) begin
      timer_control <= `TFIE_RST_TCR;
    end else if (wr_tcr) begin
      timer_control <= bus_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Compare registers
  // ----------------------------------------------------------------
  // Byte writes go straight in; the high-byte staging path is not modelled
  // Write both bytes while the counter is stopped, or a
  // half-written value may match once by accident
  // Both registers reset to all ones
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      compare_reg_a <= `TFIE_RST_CMP;
      compare_reg_b <= `TFIE_RST_CMP;
    end else if (lp_entry_i) begin
      compare_reg_a <= `TFIE_RST_CMP;
      compare_reg_b <= `TFIE_RST_CMP;
    end else begin
      compare_reg_a <= tfie_pkg::tfie_merge(compare_reg_a,
        bus_wr_i && tfie_pkg::tfie_hit(bus_addr_i, `TFIE_OFF_CMPA_H),
        bus_wr_i && tfie_pkg::tfie_hit(bus_addr_i, `TFIE_OFF_CMPA_L), bus_wdata_i);
      compare_reg_b <= tfie_pkg::tfie_merge(compare_reg_b,
        bus_wr_i && tfie_pkg::tfie_hit(bus_addr_i, `TFIE_OFF_CMPB_H),
        bus_wr_i && tfie_pkg::tfie_hit(bus_addr_i, `TFIE_OFF_CMPB_L), bus_wdata_i);
    end
  end

  // ----------------------------------------------------------------
  // Counter with compare and overflow detection
  // ----------------------------------------------------------------
  // Match and overflow pulses leave one edge after the
  // tick; the flags take them one edge later still
  // Counter byte writes land directly, with no staging
  // Low-power entry also clears the counter inside
  tfie_counter #(
    .WIDTH(WIDTH)
  ) u_counter (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(count_tick_i),
    .lp_entry_i(lp_entry_i),
    .wr_hi_i(bus_wr_i && tfie_pkg::tfie_hit(bus_addr_i, `TFIE_OFF_CNT_H)),
    .wr_lo_i(bus_wr_i && tfie_pkg::tfie_hit(bus_addr_i, `TFIE_OFF_CNT_L)),
    .wdata_i(bus_wdata_i),
    .cmp_a_i(compare_reg_a),
    .cmp_b_i(compare_reg_b),
    .clear_on_match_a_i(fl.csr[`TFIE_BIT_CLR_A]),
    .count_o(free_running_counter),
    .match_a_o(match_a),
    .match_b_o(match_b),
    .overflow_o(overflow)
  );

  // ----------------------------------------------------------------
  // Capture registers A and C
  // ----------------------------------------------------------------
  // Counter is copied regardless of flag state; buffered mode shifts A into C
  // Unbuffered, C takes its own snapshot on its own event;
  // buffered, a C event only sets its flag, so it can
  // serve as an external interrupt source
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      capture_reg_a <= `TFIE_RST_CAP;
      capture_reg_c <= `TFIE_RST_CAP;
    end else if (lp_entry_i) begin
      capture_reg_a <= `TFIE_RST_CAP;
      capture_reg_c <= `TFIE_RST_CAP;
    end else begin
      if (capture_a_i) begin
        capture_reg_a <= free_running_counter;
      end
      if (buffer_a_enable) begin
        if (capture_a_i) begin
          capture_reg_c <= capture_reg_a;
        end
      end else if (capture_c_i) begin
        capture_reg_c <= free_running_counter;
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture registers B and D
  // ----------------------------------------------------------------
  // Buffer for B is taken to be D, the pair partner of B
  // Same pattern as A and C, one pair further on
  // D follows B only while buffering B is on
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      capture_reg_b <= `TFIE_RST_CAP;
      capture_reg_d <= `TFIE_RST_CAP;
    end else if (lp_entry_i) begin
      capture_reg_b <= `TFIE_RST_CAP;
      capture_reg_d <= `TFIE_RST_CAP;
    end else begin
      if (capture_b_i) begin
        capture_reg_b <= free_running_counter;
      end
      if (buffer_b_enable) begin
        if (capture_b_i) begin
          capture_reg_d <= capture_reg_b;
        end
      end else if (capture_d_i) begin
        capture_reg_d <= free_running_counter;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flag register
  // ----------------------------------------------------------------
  // C and D events set their flags even in buffered mode, as external sources
  // Set events are one-cycle pulses
  // Low-power entry is passed on so flags and arm bits
  // clear in the same cycle
  assign fl.set_evt = {capture_a_i, capture_b_i, capture_c_i, capture_d_i,
                       match_a, match_b, overflow};
  assign fl.csr_rd = bus_rd_i && tfie_pkg::tfie_hit(bus_addr_i, `TFIE_OFF_CSR);
  assign fl.csr_wr = bus_wr_i && tfie_pkg::tfie_hit(bus_addr_i, `TFIE_OFF_CSR);
  assign fl.wdata = bus_wdata_i;
  assign fl.lp_entry = lp_entry_i;

  tfie_flags u_flags (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .fl(fl)
  );

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  // Level requests: flag AND enable, both from flip-flops
  // No extra stage: a request drops the cycle after
  // its flag is cleared or its enable written 0
  assign capture_a_irq_o = fl.csr[`TFIE_BIT_CAP_A] & timer_irq_enable[`TFIE_BIT_CAP_A];
  assign capture_b_irq_o = fl.csr[`TFIE_BIT_CAP_B] & timer_irq_enable[`TFIE_BIT_CAP_B];
  assign capture_c_irq_o = fl.csr[`TFIE_BIT_CAP_C] & timer_irq_enable[`TFIE_BIT_CAP_C];
  assign capture_d_irq_o = fl.csr[`TFIE_BIT_CAP_D] & timer_irq_enable[`TFIE_BIT_CAP_D];
  assign compare_a_irq_o = fl.csr[`TFIE_BIT_CMP_A] & timer_irq_enable[`TFIE_BIT_CMP_A];
  assign compare_b_irq_o = fl.csr[`TFIE_BIT_CMP_B] & timer_irq_enable[`TFIE_BIT_CMP_B];
  assign counter_overflow_irq_o = fl.csr[`TFIE_BIT_OVF] & timer_irq_enable[`TFIE_BIT_OVF];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero
  // Sixteen-bit registers read a byte at a time with no
  // staging; read high then low with the counter stopped
  // Every offset is decoded in full, so nothing aliases
  always_comb begin
    next_rdata = `TFIE_RD_UNMAPPED;
    unique case (bus_addr_i)
      `TFIE_OFF_IER: next_rdata = {timer_irq_enable, 1'b1};
      `TFIE_OFF_CSR: next_rdata = fl.csr;
      `TFIE_OFF_TCR: next_rdata = timer_control;
      `TFIE_OFF_CNT_H: next_rdata = free_running_counter[15:8];
      `TFIE_OFF_CNT_L: next_rdata = free_running_counter[7:0];
      `TFIE_OFF_CMPA_H: next_rdata = compare_reg_a[15:8];
      `TFIE_OFF_CMPA_L: next_rdata = compare_reg_a[7:0];
      `TFIE_OFF_CMPB_H: next_rdata = compare_reg_b[15:8];
      `TFIE_OFF_CMPB_L: next_rdata = compare_reg_b[7:0];
      `TFIE_OFF_CAPA_H: next_rdata = capture_reg_a[15:8];
      `TFIE_OFF_CAPA_L: next_rdata = capture_reg_a[7:0];
      `TFIE_OFF_CAPB_H: next_rdata = capture_reg_b[15:8];
      `TFIE_OFF_CAPB_L: next_rdata = capture_reg_b[7:0];
      `TFIE_OFF_CAPC_H: next_rdata = capture_reg_c[15:8];
      `TFIE_OFF_CAPC_L: next_rdata = capture_reg_c[7:0];
      `TFIE_OFF_CAPD_H: next_rdata = capture_reg_d[15:8];
      `TFIE_OFF_CAPD_L: next_rdata = capture_reg_d[7:0];
      default: next_rdata = `TFIE_RD_UNMAPPED;
    endcase
  end

  // Registered read data, updated only by a read strobe
  // Holding the last value lets a slow master take it late
  // A read of an unmapped offset still loads zero
  // Reset clears it so nothing unknown reaches the bus
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_rdata_o <= 8'h00;
    end else if (bus_rd_i) begin
      bus_rdata_o <= next_rdata;
    end
  end

endmodule

// ### hdl/tfie_map.svh
// Register offsets, field positions, reset values of the timer flag block
`ifndef TFIE_MAP_SVH
`define TFIE_MAP_SVH

// ----------------------------------------------------------------
// Register offsets on the 8-bit peripheral bus
// ----------------------------------------------------------------
`define TFIE_OFF_IER 8'h00
`define TFIE_OFF_CSR 8'h01
`define TFIE_OFF_TCR 8'h02
`define TFIE_OFF_CNT_H 8'h03
`define TFIE_OFF_CNT_L 8'h04
`define TFIE_OFF_CMPA_H 8'h05
`define TFIE_OFF_CMPA_L 8'h06
`define TFIE_OFF_CMPB_H 8'h07
`define TFIE_OFF_CMPB_L 8'h08
`define TFIE_OFF_CAPA_H 8'h09
`define TFIE_OFF_CAPA_L 8'h0a
`define TFIE_OFF_CAPB_H 8'h0b
`define TFIE_OFF_CAPB_L 8'h0c
`define TFIE_OFF_CAPC_H 8'h0d
`define TFIE_OFF_CAPC_L 8'h0e
`define TFIE_OFF_CAPD_H 8'h0f
`define TFIE_OFF_CAPD_L 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TFIE_BIT_CAP_A 7
`define TFIE_BIT_CAP_B 6
`define TFIE_BIT_CAP_C 5
`define TFIE_BIT_CAP_D 4
`define TFIE_BIT_CMP_A 3
`define TFIE_BIT_CMP_B 2
`define TFIE_BIT_OVF 1
`define TFIE_BIT_CLR_A 0
`define TFIE_BIT_IER_FIXED 0
`define TFIE_BIT_BUF_A 3
`define TFIE_BIT_BUF_B 2

// ----------------------------------------------------------------
// Reset values, counter maximum and unmapped read value
// ----------------------------------------------------------------
`define TFIE_RST_IER 8'h01
`define TFIE_RST_CSR 8'h00
`define TFIE_RST_TCR 8'h00
`define TFIE_RST_CNT 16'h0000
`define TFIE_RST_CMP 16'hffff
`define TFIE_RST_CAP 16'h0000
`define TFIE_CNT_MAX 16'hffff
`define TFIE_RD_UNMAPPED 8'h00

`endif

// ### hdl/tfie_pkg.sv
// Types and shared helper functions of the timer flag block
package tfie_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [7:0] tfie_byte_t;
  typedef logic [15:0] tfie_word_t;
  typedef logic [7:1] tfie_flags_t;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Address decode, shared by all write selects and the status read select
  function automatic logic tfie_hit(input tfie_byte_t addr, input tfie_byte_t off);
    return addr == off;
  endfunction

  // Byte-lane update of a 16-bit register
  function automatic tfie_word_t tfie_merge(input tfie_word_t cur, input logic hi, input logic lo,
                                            input tfie_byte_t data);
    tfie_word_t res;
    res = cur;
    if (hi) begin
      res[15:8] = data;
    end
    if (lo) begin
      res[7:0] = data;
    end
    return res;
  endfunction

endpackage

// ### hdl/tfie_flag_if.sv
// Interface between the top and the status flag register
`timescale 1ns/1ps
interface tfie_flag_if;
  tfie_pkg::tfie_flags_t set_evt;
  logic csr_rd;
  logic csr_wr;
  tfie_pkg::tfie_byte_t wdata;
  logic lp_entry;
  tfie_pkg::tfie_byte_t csr;

  modport owner (
    input set_evt,
    input csr_rd,
    input csr_wr,
    input wdata,
    input lp_entry,
    output csr
  );

  modport user (
    output set_evt,
    output csr_rd,
    output csr_wr,
    output wdata,
    output lp_entry,
    input csr
  );
endinterface

// ### hdl/tfie_flags.sv
// Control/status register: sticky event flags with read-then-write-0 clearing
`timescale 1ns/1ps
`include "tfie_map.svh"
module tfie_flags (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  tfie_flag_if.owner fl
);

  tfie_pkg::tfie_flags_t flags;
  tfie_pkg::tfie_flags_t armed;
  logic clr_on_match;
  tfie_pkg::tfie_flags_t clr_req;

  // A clear needs a prior read of 1 and a written 0
  assign clr_req = armed & ~fl.wdata[7:1] & {7{fl.csr_wr}};

  // Sticky flags; hardware set beats a same-cycle clear
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags <= '0;
    end else if (fl.lp_entry) begin
      flags <= '0;
    end else begin
      flags <= fl.set_evt | (flags & ~clr_req);
    end
  end

  // Per-flag memory of having been read as 1
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed <= '0;
    end else if (fl.lp_entry) begin
      armed <= '0;
    end else if (fl.csr_rd) begin
      armed <= flags;
    end else if (fl.csr_wr) begin
      armed <= armed & ~clr_req;
    end
  end

  // Counter-clear select is a plain read/write bit
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clr_on_match <= 1'b0;
    end else if (fl.lp_entry) begin
      clr_on_match <= 1'b0;
    end else if (fl.csr_wr) begin
      clr_on_match <= fl.wdata[`TFIE_BIT_CLR_A];
    end
  end

  assign fl.csr = {flags, clr_on_match};

endmodule

// ### hdl/tfie_counter.sv
// Free-running 16-bit up-counter with two compare matches and overflow
`timescale 1ns/1ps
`include "tfie_map.svh"
module tfie_counter #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic lp_entry_i,
  input wire logic wr_hi_i,
  input wire logic wr_lo_i,
  input wire logic [7:0] wdata_i,
  input wire logic [WIDTH-1:0] cmp_a_i,
  input wire logic [WIDTH-1:0] cmp_b_i,
  input wire logic clear_on_match_a_i,
  output logic [WIDTH-1:0] count_o,
  output logic match_a_o,
  output logic match_b_o,
  output logic overflow_o
);

  logic [WIDTH-1:0] next_count;
  logic hit_a;
  logic hit_b;

  // Compare against the live count, so a match is seen once per visit
  assign hit_a = tick_i && (count_o == cmp_a_i);
  assign hit_b = tick_i && (count_o == cmp_b_i);

  // Next count: a match A clear overrides the plain increment
  always_comb begin
    next_count = count_o;
    if (tick_i) begin
      if (hit_a && clear_on_match_a_i) begin
        next_count = '0;
      end else begin
        next_count = count_o + WIDTH'(1);
      end
    end
  end

  // Counter register; software byte writes take priority over counting
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= `TFIE_RST_CNT;
    end else if (lp_entry_i) begin
      count_o <= `TFIE_RST_CNT;
    end else if (wr_hi_i || wr_lo_i) begin
      count_o <= tfie_pkg::tfie_merge(count_o, wr_hi_i, wr_lo_i, wdata_i);
    end else begin
      count_o <= next_count;
    end
  end

  // Event pulses, registered on the same counting edge that caused them
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_a_o <= 1'b0;
      match_b_o <= 1'b0;
      overflow_o <= 1'b0;
    end else begin
      match_a_o <= hit_a && !lp_entry_i;
      match_b_o <= hit_b && !lp_entry_i;
      overflow_o <= tick_i && !lp_entry_i && !(hit_a && clear_on_match_a_i)
                    && (count_o == `TFIE_CNT_MAX) && !(wr_hi_i || wr_lo_i);
    end
  end

endmodule

// ### test/tfie_top_sva.sv
// Port-level assertions of the timer flag and enable block
`timescale 1ns/1ps
module tfie_top_sva #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic lp_entry_i,
  input wire logic count_tick_i,
  input wire logic capture_a_i,
  input wire logic capture_d_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_rdata_o,
  input wire logic capture_a_irq_o,
  input wire logic capture_b_irq_o,
  input wire logic capture_c_irq_o,
  input wire logic capture_d_irq_o,
  input wire logic compare_a_irq_o,
  input wire logic counter_overflow_irq_o
);
  // -------
  // One clock domain, one reset
  // -------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Fixed enable bit never reads back as zero
  ier_fixed_bit_a: assert property (bus_rd_i && bus_addr_i == 8'h00 |=> bus_rdata_o[0])
    else $error("enable bit 0 read as zero");
  // Low-power entry drops every request; compare B is not checked here
  lp_quiet_a: assert property (lp_entry_i |=> !(capture_a_irq_o || capture_b_irq_o || capture_c_irq_o ||
    capture_d_irq_o || compare_a_irq_o || counter_overflow_irq_o))
    else $error("request survived low-power entry");
  // A request may only appear after its event or an enable write
  cap_a_rise_a: assert property ($rose(capture_a_irq_o) |-> $past(capture_a_i) || $past(bus_wr_i))
    else $error("capture a request without cause");
  cap_d_rise_a: assert property ($rose(capture_d_irq_o) |-> $past(capture_d_i) || $past(bus_wr_i))
    else $error("capture d request without cause");
  // Counter flags follow a tick by two cycles
  cmp_a_rise_a: assert property ($rose(compare_a_irq_o) |-> $past(count_tick_i, 2) || $past(bus_wr_i))
    else $error("compare a request without tick");
  ovf_rise_a: assert property ($rose(counter_overflow_irq_o) |-> $past(count_tick_i, 2) || $past(bus_wr_i))
    else $error("overflow request without tick");
  // Flags are sticky: only software or low power removes a request
  flag_b_fall_a: assert property ($fell(capture_b_irq_o) |-> $past(bus_wr_i) || $past(lp_entry_i))
    else $error("capture b request dropped by itself");
  flag_c_fall_a: assert property ($fell(capture_c_irq_o) |-> $past(lp_entry_i) ||
    ($past(bus_wr_i) && $past(bus_addr_i) <= 8'h01))
    else $error("capture c request dropped without register write");
endmodule

bind tfie_top tfie_top_sva #(.WIDTH(WIDTH)) chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .lp_entry_i(lp_entry_i), .count_tick_i(count_tick_i),
  .capture_a_i(capture_a_i), .capture_d_i(capture_d_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i),
  .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .capture_a_irq_o(capture_a_irq_o),
  .capture_b_irq_o(capture_b_irq_o), .capture_c_irq_o(capture_c_irq_o), .capture_d_irq_o(capture_d_irq_o),
  .compare_a_irq_o(compare_a_irq_o), .counter_overflow_irq_o(counter_overflow_irq_o)
);

// ### test/tfie_top_bench.sv
// Self-checking bench of the timer flag and enable block
`timescale 1ns/1ps
`include "tfie_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module tfie_top_bench;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic lp = 1'b0;
  logic tick = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] cap = 4'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [6:0] irq;
  int errors = 0;
  int checks = 0;

  // -------
  // Device and clock; irq bit k pairs with enable bit k+1
  // -------
  tfie_top #(.WIDTH(16)) uut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .lp_entry_i(lp), .count_tick_i(tick),
    .capture_a_i(cap[3]), .capture_b_i(cap[2]), .capture_c_i(cap[1]), .capture_d_i(cap[0]),
    .bus_addr_i(addr), .bus_wr_i(wr), .bus_rd_i(rd), .bus_wdata_i(wd), .bus_rdata_o(rdata),
    .capture_a_irq_o(irq[6]), .capture_b_irq_o(irq[5]), .capture_c_irq_o(irq[4]),
    .capture_d_irq_o(irq[3]), .compare_a_irq_o(irq[2]), .compare_b_irq_o(irq[1]),
    .counter_overflow_irq_o(irq[0])
  );

  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // -------
  // Bus and event tasks
  // -------
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
    #1;
  endtask

  // Read data is registered, so it is taken just after the sampling edge
  task automatic rd8(input logic [7:0] a);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // High byte first; there is no staging byte
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr8(a, d[15:8]);
    wr8(a + 8'h01, d[7:0]);
  endtask

  task automatic chk16(input logic [7:0] a, input logic [15:0] e);
    rd8(a);
    `CHK(v, e[15:8])
    rd8(a + 8'h01);
    `CHK(v, e[7:0])
  endtask

  // One-cycle pulse, then a spare cycle so counter flags have landed
  task automatic ev(input logic [3:0] c, input logic t);
    @(posedge sys_clk_i);
    cap <= c;
    tick <= t;
    @(posedge sys_clk_i);
    cap <= 4'h0;
    tick <= 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    $display("mismatch at %0t: run did not finish", $time);
    end_of_test();
  end

  // -------
  // Test sequence
  // -------
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd8(`TFIE_OFF_IER);
    `CHK(v, 8'h01)
    rd8(`TFIE_OFF_CSR);
    `CHK(v, 8'h00)
    wr8(`TFIE_OFF_IER, 8'h00);
    wr8(`TFIE_OFF_CSR, 8'hfe);
    rd8(`TFIE_OFF_IER);
    `CHK(v, 8'h01)
    rd8(`TFIE_OFF_CSR);
    `CHK(v, 8'h00)
    rd8(8'h7f);
    `CHK(v, 8'h00)
    $display("test reset_values done");
    // Unread flag survives a 0 write; read then 0 clears it
    for (int i = 0; i < 4; i++) begin
      wr8(`TFIE_OFF_IER, 8'h80 >> i);
      ev(4'h8 >> i, 1'b0);
      `CHK(irq, 7'h40 >> i)
      wr8(`TFIE_OFF_CSR, 8'h00);
      rd8(`TFIE_OFF_CSR);
      `CHK(v, 8'h80 >> i)
      wr8(`TFIE_OFF_IER, 8'h00);
      `CHK(irq, 7'h00)
      wr8(`TFIE_OFF_CSR, 8'h00);
      rd8(`TFIE_OFF_CSR);
      `CHK(v, 8'h00)
    end
    $display("test capture_flags done");
    // Both buffers on; C and D events fire with A and B
    wr8(`TFIE_OFF_TCR, 8'h0c);
    wr16(`TFIE_OFF_CNT_H, 16'h1234);
    ev(4'hc, 1'b0);
    wr16(`TFIE_OFF_CNT_H, 16'h5678);
    ev(4'hf, 1'b0);
    chk16(`TFIE_OFF_CAPA_H, 16'h5678);
    chk16(`TFIE_OFF_CAPC_H, 16'h1234);
    chk16(`TFIE_OFF_CAPD_H, 16'h1234);
    rd8(`TFIE_OFF_CSR);
    `CHK(v, 8'hf0)
    wr8(`TFIE_OFF_CSR, 8'h00);
    $display("test buffering done");
    // Match A with clear-on-match, then plain matches A and B
    wr8(`TFIE_OFF_IER, 8'h0c);
    wr16(`TFIE_OFF_CMPA_H, 16'h0005);
    wr16(`TFIE_OFF_CMPB_H, 16'h0006);
    wr16(`TFIE_OFF_CNT_H, 16'h0005);
    wr8(`TFIE_OFF_CSR, 8'h01);
    ev(4'h0, 1'b1);
    `CHK(irq, 7'h04)
    chk16(`TFIE_OFF_CNT_H, 16'h0000);
    rd8(`TFIE_OFF_CSR);
    `CHK(v, 8'h09)
    wr8(`TFIE_OFF_CSR, 8'h00);
    wr16(`TFIE_OFF_CNT_H, 16'h0005);
    ev(4'h0, 1'b1);
    ev(4'h0, 1'b1);
    chk16(`TFIE_OFF_CNT_H, 16'h0007);
    `CHK(irq, 7'h06)
    rd8(`TFIE_OFF_CSR);
    `CHK(v, 8'h0c)
    wr8(`TFIE_OFF_CSR, 8'h00);
    $display("test compare done");
    wr8(`TFIE_OFF_IER, 8'h02);
    wr16(`TFIE_OFF_CNT_H, `TFIE_CNT_MAX);
    ev(4'h0, 1'b1);
    `CHK(irq, 7'h01)
    chk16(`TFIE_OFF_CNT_H, 16'h0000);
    rd8(`TFIE_OFF_CSR);
    `CHK(v, 8'h02)
    $display("test overflow done");
    @(posedge sys_clk_i);
    lp <= 1'b1;
    @(posedge sys_clk_i);
    lp <= 1'b0;
    rd8(`TFIE_OFF_IER);
    `CHK(v, 8'h01)
    rd8(`TFIE_OFF_CSR);
    `CHK(v, 8'h00)
    `CHK(irq, 7'h00)
    $display("test low_power done");
    // Armed clear and capture in one cycle: the event must not be lost
    ev(4'h8, 1'b0);
    rd8(`TFIE_OFF_CSR);
    @(posedge sys_clk_i);
    addr <= `TFIE_OFF_CSR;
    wd <= 8'h00;
    wr <= 1'b1;
    cap <= 4'h8;
    @(posedge sys_clk_i);
    wr <= 1'b0;
    cap <= 4'h0;
    rd8(`TFIE_OFF_CSR);
    `CHK(v, 8'h80)
    $display("test set_wins done");
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd8(`TFIE_OFF_CSR);
    `CHK(v, 8'h00)
    $display("test second_reset done");
    end_of_test();
  end
endmodule
